// file: jpt_master_model.sv
/*
 * behavioural scan master that drives one backplane port.
 * assumes the bench routes these pins to whichever port the strap made master.
 */
`timescale 1ns/10ps
`default_nettype none
module jpt_master_model (
    output logic o_tck,
    output logic o_tms,
    output logic o_tdi,
    output logic o_trst_n
);
    // ----------------
    // idle levels
    // ----------------
    // pull-ups hold tms and tdi high; tck stands low outside frames
    initial begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b1;
        o_trst_n = 1'b1;
    end
    // ----------------
    // scan tasks
    // ----------------
    // one 80 ns tck period, data set while tck low and held past the rise
    task automatic tick(input logic tms, input logic tdi);
        o_tms = tms;
        o_tdi = tdi;
        #40 o_tck = 1'b1;
        #40 o_tck = 1'b0;
    endtask : tick
    task automatic set_tck(input logic v);
        o_tck = v;
    endtask : set_tck
    // select, shift, eight bits lsb first, exit, update
    task automatic scan(input logic [7:0] val);
        tick(1'b1, 1'b1);
        tick(1'b0, 1'b1);
        for (int i = 0; i < 8; i++) begin
            tick(i == 7, val[i]);
        end
        tick(1'b1, ~val[7]);
        o_tdi = 1'b1;
    endtask : scan
    task automatic pulse_trst();
        o_trst_n = 1'b0;
        #80 o_trst_n = 1'b1;
    endtask : pulse_trst
endmodule : jpt_master_model
`default_nettype wire

// file: jpt_pkg.sv
/*
 * package for the scan-path mux pass-through / transparent block: override register layout,
 * instruction codes, strap settle count and scan pad depth.
 * assumes a single 125 MHz system clock and synchronous active-high reset.
 */
package jpt_pkg;
    localparam int OVR_W = 8;
    localparam logic [7:0] OVR_RESET = 8'h00;
    localparam logic [7:0] INSTR_OVERRIDE = 8'hBF;
    localparam logic [7:0] INSTR_TRANSPARENT = 8'hBE; // arbitrary code for the mode instruction
    localparam int IR_W = 8;
    localparam int PAD_STAGES = 2;
    // edges after reset release until a strap has crossed the input filter
    localparam int SYNC_SETTLE = 5;
    localparam int LP0_Y0_DATA = 0;
    localparam int LP0_Y0_EN = 1;
    localparam int LP0_Y1_DATA = 2;
    localparam int LP0_Y1_EN = 3;
    localparam int LP1_Y0_DATA = 4;
    localparam int LP1_Y0_EN = 5;
    localparam int LP1_Y1_DATA = 6;
    localparam int LP1_Y1_EN = 7;
    localparam int NUM_LOCAL = 2;
endpackage : jpt_pkg

// file: jpt_sync3.sv
/*
 * three-flop input conditioner with agreement filter.
 * assumes asynchronous input and the block clock.
 */
`timescale 1ns/10ps
`default_nettype none
module jpt_sync3 #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] s1_r, s2_r, s3_r, q_r, q_nxt;
    always_comb begin
        q_nxt = q_r;
        // first stage feeds only the second; agreement of second and third
        for (int k = 0; k < W; k++) begin
            if (s2_r[k] == s3_r[k]) begin
                q_nxt[k] = s2_r[k];
            end
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            q_r <= '0;
        end else begin
            s1_r <= i_d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q_r <= q_nxt;
        end
    end
    assign o_q = q_r;
endmodule : jpt_sync3
`default_nettype wire

// file: jpt_top.sv
/*
 * pass-through, master select and transparent path of the scan mux.
 * assumes the master's tck/tms/tdi/trst arrive asynchronously and are sampled at 125 MHz;
 * the instruction register value and multi-select flag come from the tap logic elsewhere.
 */
`timescale 1ns/10ps
`default_nettype none
module jpt_top #(
    parameter int PADS = jpt_pkg::PAD_STAGES
) (
    input wire logic I_MCLK,
    input wire logic I_RST,
    input wire logic I_MASTER_PORT_CHOICE,
    input wire logic I_BRIDGE_MODE,
    input wire logic I_TRANSPARENT_PIN,
    input wire logic I_MULTI_SELECT,
    input wire logic [7:0] I_IR,
    input wire logic I_TCK_A,
    input wire logic I_TMS_A,
    input wire logic I_TDI_A,
    input wire logic I_TRST_N_A,
    input wire logic I_TCK_B,
    input wire logic I_TMS_B,
    input wire logic I_TDI_B,
    input wire logic I_TRST_N_B,
    input wire logic I_LOCAL_TDO,
    input wire logic [1:0] I_PT_IN_A,
    input wire logic [1:0] I_PT_IN_B,
    input wire logic [1:0] I_PT_IN_L1,
    output logic o_TCK_L,
    output logic o_TMS_L,
    output logic o_TDI_L,
    output logic o_TRST_N_L,
    output logic o_TDO_M,
    output logic o_MASTER_IS_B,
    output logic o_TRANSPARENT,
    output logic [7:0] o_OVR_BITS,
    output logic [1:0] o_PT_OUT_A,
    output logic [1:0] o_PT_OUT_B,
    output logic [1:0] o_PT_OUT_L1
);
    // ------------------------------------------------------------
    // input conditioning
    // ------------------------------------------------------------
    logic [12:0] raw, syn;
    assign raw = {I_TCK_A, I_TMS_A, I_TDI_A, I_TRST_N_A, I_TCK_B, I_TMS_B, I_TDI_B,
                  I_TRST_N_B, I_LOCAL_TDO, I_TRANSPARENT_PIN, I_MASTER_PORT_CHOICE,
                  I_BRIDGE_MODE, I_MULTI_SELECT};
    jpt_sync3 #(.W(13)) u_sync (
        .i_clk(I_MCLK),
        .i_rst(I_RST),
        .i_d(raw),
        .o_q(syn)
    );
    logic tck_a, tms_a, tdi_a, trst_a, tck_b, tms_b, tdi_b, trst_b, ltdo, tpin, msel, brg, multi;
    assign {tck_a, tms_a, tdi_a, trst_a, tck_b, tms_b, tdi_b, trst_b, ltdo, tpin, msel, brg,
            multi} = syn;

    // ------------------------------------------------------------
    // strap capture and mode
    // ------------------------------------------------------------
    // filter is cleared in reset, so the strap is followed until it is through
    logic mb_r, mb_nxt, transparent_pin_r, transparent_pin_nxt, settled;
    logic [2:0] settle_r, settle_nxt;
    assign settled = (settle_r == 3'(jpt_pkg::SYNC_SETTLE));
    always_comb begin
        settle_nxt = settled ? settle_r : settle_r + 3'h1;
        mb_nxt = (I_RST || !settled) ? msel : mb_r;
        transparent_pin_nxt = brg ? (I_IR == jpt_pkg::INSTR_TRANSPARENT) : tpin;
    end
    always_ff @(posedge I_MCLK) begin
        mb_r <= mb_nxt;
        if (I_RST) begin
            transparent_pin_r <= 1'b0;
            settle_r <= 3'h0;
        end else begin
            transparent_pin_r <= transparent_pin_nxt;
            settle_r <= settle_nxt;
        end
    end

    // master signals picked by strap: low = port a, high = port b
    logic m_tck, m_tms, m_tdi, m_trst;
    assign m_tck = mb_r ? tck_b : tck_a;
    assign m_tms = mb_r ? tms_b : tms_a;
    assign m_tdi = mb_r ? tdi_b : tdi_a;
    assign m_trst = mb_r ? trst_b : trst_a;

    // ------------------------------------------------------------
    // tck edge detect and pad stages
    // ------------------------------------------------------------
    logic tck_d_r, tck_rise, tck_fall;
    assign tck_rise = m_tck & ~tck_d_r;
    assign tck_fall = ~m_tck & tck_d_r;
    logic [PADS-1:0] pad_r, pad_nxt;
    logic tdo_r, tdo_nxt, tms_r, tdi_r, tck_r, trst_r, lin_nxt;
    always_comb begin
        pad_nxt = pad_r;
        // pads cost latency but relax timing at fast tck
        if (tck_rise) begin
            pad_nxt = {pad_r[PADS-2:0], ltdo};
        end
        tdo_nxt = tdo_r;
        if (tck_fall) begin
            tdo_nxt = transparent_pin_r ? ltdo : pad_r[PADS-1];
        end
        lin_nxt = tdi_r;
        if (tck_fall) begin
            lin_nxt = m_tdi;
        end
    end
    always_ff @(posedge I_MCLK) begin
        tck_d_r <= I_RST ? 1'b0 : m_tck;
        tck_r <= I_RST ? 1'b0 : m_tck;
        tms_r <= I_RST ? 1'b1 : m_tms;
        trst_r <= I_RST ? 1'b0 : m_trst;
        if (I_RST) begin
            pad_r <= '0;
            tdo_r <= 1'b0;
            tdi_r <= 1'b0;
        end else begin
            pad_r <= pad_nxt;
            tdo_r <= tdo_nxt;
            tdi_r <= lin_nxt;
        end
    end
    // transparent: filtered master signals skip the tck_r/tms_r/tdi_r/trst_r stage
    assign o_TCK_L = transparent_pin_r ? m_tck : tck_r;
    assign o_TMS_L = transparent_pin_r ? m_tms : tms_r;
    assign o_TDI_L = transparent_pin_r ? m_tdi : tdi_r;
    assign o_TRST_N_L = transparent_pin_r ? m_trst : trst_r;
    assign o_TDO_M = tdo_r;
    assign o_MASTER_IS_B = mb_r;
    assign o_TRANSPARENT = transparent_pin_r;

    // ------------------------------------------------------------
    // override register, shifted by data scan while override held
    // ------------------------------------------------------------
    logic ovr_act;
    assign ovr_act = (I_IR == jpt_pkg::INSTR_OVERRIDE);
    logic [7:0] sh_r, sh_nxt, ovr_r, ovr_nxt;
    logic [3:0] tap_r, tap_nxt; // minimal dr-path tracker: 0 idle,1 select,2 shift,3 exit/pause
    always_comb begin
        sh_nxt = sh_r;
        ovr_nxt = ovr_r;
        tap_nxt = tap_r;
        if (tck_rise) begin
            unique case (tap_r)
                4'h0: tap_nxt = m_tms ? 4'h1 : 4'h0;
                4'h1: tap_nxt = m_tms ? 4'h0 : 4'h2;
                4'h2: begin
                    sh_nxt = {m_tdi, sh_r[7:1]};
                    tap_nxt = m_tms ? 4'h3 : 4'h2;
                end
                4'h3: begin
                    tap_nxt = m_tms ? 4'h0 : 4'h2;
                    if (m_tms && ovr_act) begin
                        ovr_nxt = sh_r;
                    end
                end
                default: tap_nxt = 4'h0;
            endcase
        end
    end
    always_ff @(posedge I_MCLK) begin
        if (I_RST || !m_trst) begin
            sh_r <= '0;
            ovr_r <= jpt_pkg::OVR_RESET;
            tap_r <= 4'h0;
        end else begin
            sh_r <= sh_nxt;
            ovr_r <= ovr_nxt;
            tap_r <= tap_nxt;
        end
    end
    assign o_OVR_BITS = ovr_r;

    // ------------------------------------------------------------
    // pass-through outputs
    // ------------------------------------------------------------
    logic [1:0] pa, pb, pl1, m_in, l0_in, l0_out, l1_out, m_out;
    jpt_sync3 #(.W(6)) u_psync (
        .i_clk(I_MCLK),
        .i_rst(I_RST),
        .i_d({I_PT_IN_A, I_PT_IN_B, I_PT_IN_L1}),
        .o_q({pa, pb, pl1})
    );
    assign m_in = mb_r ? pb : pa;
    assign l0_in = mb_r ? pa : pb;
    logic [1:0] l0_r, l1_r, mo_r;
    always_comb begin
        l0_out = m_in;
        l1_out = m_in;
        m_out = l0_in;
        if (ovr_act) begin
            if (ovr_r[jpt_pkg::LP0_Y0_EN]) l0_out[0] = ovr_r[jpt_pkg::LP0_Y0_DATA];
            if (ovr_r[jpt_pkg::LP0_Y1_EN]) l0_out[1] = ovr_r[jpt_pkg::LP0_Y1_DATA];
            if (ovr_r[jpt_pkg::LP1_Y0_EN]) l1_out[0] = ovr_r[jpt_pkg::LP1_Y0_DATA];
            if (ovr_r[jpt_pkg::LP1_Y1_EN]) l1_out[1] = ovr_r[jpt_pkg::LP1_Y1_DATA];
        end
        if (multi) begin
            // unavailable under multi-select: park low
            l0_out = 2'h0;
            l1_out = 2'h0;
            m_out = 2'h0;
        end
    end
    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            l0_r <= 2'h0;
            l1_r <= 2'h0;
            mo_r <= 2'h0;
        end else begin
            l0_r <= l0_out;
            l1_r <= l1_out;
            mo_r <= m_out;
        end
    end
    assign o_PT_OUT_A = mb_r ? l0_r : mo_r;
    assign o_PT_OUT_B = mb_r ? mo_r : l0_r;
    assign o_PT_OUT_L1 = l1_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_ovr_reset;
        @(posedge I_MCLK) I_RST |=> (ovr_r == 8'h00);
    endproperty
    a_ovr_reset: assert property (p_ovr_reset) else $error("override not cleared");
    property p_transparent_pin_buf;
        @(posedge I_MCLK) disable iff (I_RST) (transparent_pin_r && tck_fall) |=> (tdo_r == $past(ltdo));
    endproperty
    a_transparent_pin_buf: assert property (p_transparent_pin_buf) else $error("transparent not buffered");
    property p_strap;
        @(posedge I_MCLK) disable iff (I_RST) settled |=> $stable(mb_r);
    endproperty
    a_strap: assert property (p_strap) else $error("master moved out of reset");
    property p_follow;
        @(posedge I_MCLK) disable iff (I_RST) (!ovr_act && !multi) |=> (l1_r == $past(m_in));
    endproperty
    a_follow: assert property (p_follow) else $error("passthru not following");
    property p_ovr_drive;
        @(posedge I_MCLK) disable iff (I_RST)
            (ovr_act && !multi && ovr_r[jpt_pkg::LP1_Y0_EN]) |=>
            (l1_r[0] == $past(ovr_r[jpt_pkg::LP1_Y0_DATA]));
    endproperty
    a_ovr_drive: assert property (p_ovr_drive) else $error("override not driven");
    property p_multi;
        @(posedge I_MCLK) disable iff (I_RST) multi |=> (l0_r == 2'h0 && mo_r == 2'h0);
    endproperty
    a_multi: assert property (p_multi) else $error("passthru under multi-select");
    property p_transparent_pin_mode;
        @(posedge I_MCLK) disable iff (I_RST) (!brg && tpin) |=> transparent_pin_r;
    endproperty
    a_transparent_pin_mode: assert property (p_transparent_pin_mode) else $error("pin did not set transparent");
    property p_pad;
        @(posedge I_MCLK) disable iff (I_RST)
            (!transparent_pin_r && tck_fall) |=> (tdo_r == $past(pad_r[PADS-1]));
    endproperty
    a_pad: assert property (p_pad) else $error("pad stage skipped");
    c_transparent_pin: cover property (@(posedge I_MCLK) transparent_pin_r);
    c_ovr: cover property (@(posedge I_MCLK) ovr_act && ovr_r != 8'h00);
    c_mb: cover property (@(posedge I_MCLK) mb_r);
endmodule : jpt_top
`default_nettype wire

// file: tb_jpt_top.sv
/*
 * self-checking bench for pass-through, master select and transparent path.
 * assumes jpt_pkg, jpt_top and jpt_master_model are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_jpt_top;
    typedef struct packed {
        logic [7:0] ir;
        logic mul;
        logic [1:0] a, b, ea, eb, el;
    } jpt_row_t;
    // override value b6: local_port_zero y0 forced 0, y1 free; local_port_one forced to 01
    localparam jpt_row_t ROWS [6] = '{
        '{8'h00, 1'b0, 2'h1, 2'h2, 2'h2, 2'h1, 2'h1},
        '{8'h00, 1'b0, 2'h2, 2'h1, 2'h1, 2'h2, 2'h2},
        '{8'hBF, 1'b0, 2'h3, 2'h0, 2'h0, 2'h2, 2'h1},
        '{8'hBF, 1'b0, 2'h0, 2'h3, 2'h3, 2'h0, 2'h1},
        '{8'h00, 1'b1, 2'h3, 2'h3, 2'h0, 2'h0, 2'h0},
        '{8'hBF, 1'b1, 2'h3, 2'h3, 2'h0, 2'h0, 2'h0}};
    logic I_MCLK, I_RST, strap, bridge, tpin, multi, ltdo;
    logic [7:0] ir, ovr;
    logic [1:0] pa, pb, pl1, qa, qb, ql1;
    logic m_tck, m_tms, m_tdi, m_trst_n, tck_l, is_b, transp;
    logic q_tck, q_tms, q_tdi, q_trst_n, tms_l, tdi_l, trst_l, tdo_m;
    int bad_count = 0;
    int num_checks = 0;
    int cyc = 0;
    // ----------------
    // design and master
    // ----------------
    jpt_master_model i_jpt_master_model (.o_tck(m_tck), .o_tms(m_tms), .o_tdi(m_tdi),
        .o_trst_n(m_trst_n));
    jpt_top #(.PADS(jpt_pkg::PAD_STAGES)) i_jpt_top (.I_MCLK(I_MCLK), .I_RST(I_RST),
        .I_MASTER_PORT_CHOICE(strap), .I_BRIDGE_MODE(bridge), .I_TRANSPARENT_PIN(tpin),
        .I_MULTI_SELECT(multi), .I_IR(ir), .I_TCK_A(strap ? q_tck : m_tck),
        .I_TMS_A(strap ? q_tms : m_tms), .I_TDI_A(strap ? q_tdi : m_tdi),
        .I_TRST_N_A(strap ? q_trst_n : m_trst_n), .I_TCK_B(strap ? m_tck : q_tck),
        .I_TMS_B(strap ? m_tms : q_tms), .I_TDI_B(strap ? m_tdi : q_tdi),
        .I_TRST_N_B(strap ? m_trst_n : q_trst_n), .I_LOCAL_TDO(ltdo), .I_PT_IN_A(pa),
        .I_PT_IN_B(pb), .I_PT_IN_L1(pl1), .o_TCK_L(tck_l), .o_TMS_L(tms_l),
        .o_TDI_L(tdi_l), .o_TRST_N_L(trst_l), .o_TDO_M(tdo_m), .o_MASTER_IS_B(is_b),
        .o_TRANSPARENT(transp),
        .o_OVR_BITS(ovr), .o_PT_OUT_A(qa), .o_PT_OUT_B(qb), .o_PT_OUT_L1(ql1));
    // ----------------
    // helpers
    // ----------------
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic results();
        if (bad_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results
    task automatic wait_n(input int n);
        repeat (n) @(negedge I_MCLK);
    endtask : wait_n
    // strap moves only under reset, since it is sampled in the settle cycles right after release
    task automatic do_reset(input logic s);
        @(negedge I_MCLK);
        I_RST = 1'b1;
        strap = s;
        wait_n(2);
        I_RST = 1'b0;
        wait_n(8);
    endtask : do_reset
    initial begin
        I_MCLK = 1'b0;
        forever #4 I_MCLK = ~I_MCLK;
    end
    // inputs pass a 3-flop filter, so 8 cycles covers the 5-cycle latency
    always @(posedge I_MCLK) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            results();
        end
    end
    // ----------------
    // main sequence
    // ----------------
    initial begin
        I_RST = 1'b1;
        strap = 1'b0;
        bridge = 1'b0;
        tpin = 1'b0;
        multi = 1'b0;
        ltdo = 1'b0;
        ir = 8'h00;
        pa = 2'h0;
        pb = 2'h0;
        pl1 = 2'h3;
        q_tck = 1'b0;
        q_tms = 1'b1;
        q_tdi = 1'b1;
        q_trst_n = 1'b1;
        do_reset(1'b0);
        chk("ovr_rst", 8'h00, ovr);
        chk("is_b", 8'h00, 8'(is_b));
        chk("transp", 8'h00, 8'(transp));
        chk("tms_l", 8'h01, 8'(tms_l));
        chk("trst_l", 8'h01, 8'(trst_l));
        ltdo = 1'b1;
        i_jpt_master_model.tick(1'b1, 1'b1);
        wait_n(8);
        chk("pad_first", 8'h00, 8'(tdo_m));
        chk("tdi_l_one", 8'h01, 8'(tdi_l));
        i_jpt_master_model.tick(1'b1, 1'b0);
        wait_n(8);
        chk("pad_second", 8'h01, 8'(tdo_m));
        chk("tdi_l_zero", 8'h00, 8'(tdi_l));
        ltdo = 1'b0;
        ir = 8'hBF;
        i_jpt_master_model.scan(8'hB6);
        wait_n(4);
        chk("ovr_load", 8'hB6, ovr);
        q_tck = 1'b1;
        q_trst_n = 1'b0;
        wait_n(8);
        chk("quiet_tck", 8'h00, 8'(tck_l));
        chk("quiet_trst", 8'hB6, ovr);
        q_tck = 1'b0;
        q_trst_n = 1'b1;
        wait_n(8);
        foreach (ROWS[k]) begin
            ir = ROWS[k].ir;
            multi = ROWS[k].mul;
            pa = ROWS[k].a;
            pb = ROWS[k].b;
            wait_n(8);
            chk("pt_a", 8'(ROWS[k].ea), 8'(qa));
            chk("pt_b", 8'(ROWS[k].eb), 8'(qb));
            chk("pt_l1", 8'(ROWS[k].el), 8'(ql1));
        end
        multi = 1'b0;
        ir = 8'h00;
        i_jpt_master_model.scan(8'hFF);
        wait_n(4);
        chk("ovr_refused", 8'hB6, ovr);
        ir = 8'hBF;
        i_jpt_master_model.scan(8'hFF);
        wait_n(4);
        chk("ovr_ff", 8'hFF, ovr);
        i_jpt_master_model.pulse_trst();
        wait_n(8);
        chk("ovr_trst", 8'h00, ovr);
        tpin = 1'b1;
        wait_n(8);
        chk("transp_pin", 8'h01, 8'(transp));
        i_jpt_master_model.set_tck(1'b1);
        wait_n(8);
        chk("tck_through", 8'h01, 8'(tck_l));
        i_jpt_master_model.set_tck(1'b0);
        tpin = 1'b0;
        wait_n(8);
        chk("transp_off", 8'h00, 8'(transp));
        bridge = 1'b1;
        ir = jpt_pkg::INSTR_TRANSPARENT;
        wait_n(8);
        chk("transp_instr", 8'h01, 8'(transp));
        ir = 8'h00;
        bridge = 1'b0;
        pa = 2'h1;
        pb = 2'h2;
        do_reset(1'b1);
        chk("is_b", 8'h01, 8'(is_b));
        chk("b_pt_a", 8'h02, 8'(qa));
        chk("b_pt_b", 8'h01, 8'(qb));
        chk("b_pt_l1", 8'h02, 8'(ql1));
        ir = 8'hBF;
        i_jpt_master_model.scan(8'h0F);
        wait_n(8);
        chk("b_ovr", 8'h0F, ovr);
        chk("b_ovr_a", 8'h03, 8'(qa));
        results();
    end
endmodule : tb_jpt_top
`default_nettype wire
